// File: rtl/csa_channel_status.sv
// Per-channel status accumulation, block status and firmware working bytes
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module csa_channel_status
	import csa_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic [NUM_CHAN-1:0] BLK_START,
	input wire logic [NUM_CHAN-1:0] BLK_END,
	input wire logic VARIANT_SPLIT,
	input wire logic [NUM_CHAN-1:0] INTERRUPT_REQUEST_INSTR_INSTR,
	input wire logic [NUM_CHAN-1:0] DSET_INTERRUPT_REQUEST_INSTR,
	input wire csa_status_event_type [NUM_CHAN-1:0] STATUS_EVT,
	input wire logic [NUM_CHAN-1:0] APP_WR,
	input wire logic [NUM_CHAN-1:0] [1:0] APP_BITS,
	input wire logic BMR_START,
	input wire logic BMR_TX_CHAN,
	input wire logic [15:0] BMR_ADDR,
	input wire logic [15:0] BMR_RANGE,
	input wire logic [NUM_CHAN-1:0] FUNC_ACCEPT,
	input wire logic [9:0] FUNC_CHAN_ADDR,
	input wire logic [NUM_CHAN-1:0] IND_WR,
	input wire logic [2:0] IND_IN,
	input wire logic [NUM_CHAN-1:0] SUB_BRANCH,
	input wire logic [11:0] RET_ADDR_IN,
	input wire logic [NUM_CHAN-1:0] R_SAVE,
	input wire logic [NUM_CHAN-1:0] R_RESTORE,
	input wire logic [7:0] R_IN,
	input wire logic TPTR_WR,
	input wire logic [5:0] TPTR_IN,
	input wire logic [5:0] PROG_RD_ADDR,
	input wire logic HOST_TBL_RD,
	input wire logic [NUM_CHAN-1:0] HOST_STAT_RD,
	output logic [7:0] PROG_RD_DATA,
	output logic [7:0] HOST_TBL_DATA,
	output logic HOST_TBL_VALID,
	output csa_blk_status_type [NUM_CHAN-1:0] BLK_STATUS,
	output logic [NUM_CHAN-1:0] BLK_STATUS_MEANINGFUL,
	output csa_blk_status_type HOST_STAT_DATA,
	output logic HOST_STAT_VALID,
	output logic [NUM_CHAN-1:0] CHAN_ACTIVE,
	output logic [NUM_CHAN-1:0] [2:0] INDICATORS,
	output logic [NUM_CHAN-1:0] [11:0] RET_ADDR,
	output logic [7:0] R_OUT,
	output logic R_OUT_VALID,
	output logic BMR_BUSY,
	output logic [15:0] BMR_RAM_ADDR,
	output logic BMR_REJECT
);

	// ------------------------------------------------------------------
	// Per-channel state
	// ------------------------------------------------------------------
	logic [NUM_CHAN-1:0] [7:0] st1_q;
	logic [NUM_CHAN-1:0] [7:0] st2_q;
	logic [NUM_CHAN-1:0] [9:0] chan_q;
	logic [NUM_CHAN-1:0] [7:0] ind_q;
	logic [NUM_CHAN-1:0] [7:0] reth_q;
	logic [NUM_CHAN-1:0] [7:0] retl_q;
	logic [NUM_CHAN-1:0] [7:0] rsav_q;
	csa_blk_status_type [NUM_CHAN-1:0] blk_q;
	logic [NUM_CHAN-1:0] meaningful_q;
	csa_state_type [NUM_CHAN-1:0] state_q;
	logic [5:0] tptr_q;
	logic [15:0] bmr_addr_q;
	logic [15:0] bmr_left_q;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CHAN; gi++)
		begin : g_chan
			logic active;
			logic [7:0] st1_set;
			logic [7:0] st2_set;
			logic bmr_here;
			assign active = (state_q[gi] == CSA_ACTIVE);
			assign bmr_here = (state_q[gi] == CSA_BMR);

			// Bits that hardware events set this cycle
			always_comb
			begin
				st1_set = STATUS_EVT[gi].set_valid ? STATUS_EVT[gi].set_mask : 8'h00;
				st2_set = STATUS_EVT[gi].set_valid ? STATUS_EVT[gi].set_mask2 : 8'h00;
				st1_set[BIT_INTERRUPT_REQUEST_INSTR] = st1_set[BIT_INTERRUPT_REQUEST_INSTR] | INTERRUPT_REQUEST_INSTR_INSTR[gi];
				st2_set[BIT_DSET] = st2_set[BIT_DSET] | DSET_INTERRUPT_REQUEST_INSTR[gi];
			end

			// Channel state: idle, active block, block mode read
			always_ff @(posedge CLK or posedge RST)
			begin
				if (RST)
					state_q[gi] <= CSA_IDLE;
				else
				begin
					case (state_q[gi])
						CSA_IDLE:
						begin
							if (gi == 0 && BMR_START && !BMR_TX_CHAN)
								state_q[gi] <= CSA_BMR;
							else if (BLK_START[gi])
								state_q[gi] <= CSA_ACTIVE;
						end
						CSA_ACTIVE:
						begin
							if (BLK_END[gi])
								state_q[gi] <= CSA_IDLE;
						end
						CSA_BMR:
						begin
							if (bmr_left_q == 16'h0000)
								state_q[gi] <= CSA_IDLE;
						end
						default:
							state_q[gi] <= CSA_IDLE;
					endcase
				end
			end

			// Status accumulation, then copy and clear in one edge
			always_ff @(posedge CLK or posedge RST)
			begin
				if (RST)
				begin
					st1_q[gi] <= BYTE_RST;
					st2_q[gi] <= BYTE_RST;
				end
				else if (active && BLK_END[gi])
				begin
					st1_q[gi] <= BYTE_RST;
					st2_q[gi] <= BYTE_RST;
				end
				else if (active)
				begin
					st1_q[gi] <= st1_q[gi] | st1_set;
					st2_q[gi] <= st2_q[gi] | st2_set;
					if (APP_WR[gi])
					begin
						st1_q[gi][BIT_APP_HI] <= APP_BITS[gi][1] | st1_set[BIT_APP_HI];
						st1_q[gi][BIT_APP_LO] <= APP_BITS[gi][0] | st1_set[BIT_APP_LO];
					end
				end
			end

			// Block status field written at completion, and loaded with the walker address in block mode read
			always_ff @(posedge CLK or posedge RST)
			begin
				if (RST)
				begin
					blk_q[gi] <= '0;
					meaningful_q[gi] <= 1'b0;
				end
				else if (active && BLK_END[gi])
				begin
					meaningful_q[gi] <= 1'b1;
					if (VARIANT_SPLIT)
					begin
						blk_q[gi].byte6 <= st2_q[gi] | st2_set;
						blk_q[gi].byte7 <= st1_q[gi] | st1_set;
						blk_q[gi].byte6[BIT_VALID] <= 1'b1;
						blk_q[gi].byte6[BIT_INTERRUPT_REQUEST_INSTR] <= st1_q[gi][BIT_INTERRUPT_REQUEST_INSTR] | st1_set[BIT_INTERRUPT_REQUEST_INSTR];
					end
					else
					begin
						blk_q[gi].byte6 <= st2_q[gi] | st2_set;
						blk_q[gi].byte7 <= st1_q[gi] | st1_set;
						blk_q[gi].byte7[BIT_VALID] <= 1'b1;
						blk_q[gi].byte7[BIT_INTERRUPT_REQUEST_INSTR] <= st1_q[gi][BIT_INTERRUPT_REQUEST_INSTR] | st1_set[BIT_INTERRUPT_REQUEST_INSTR];
					end
				end
				else if (bmr_here)
				begin
					blk_q[gi] <= bmr_addr_q;
					meaningful_q[gi] <= 1'b0;
				end
			end

			// Firmware working bytes
			always_ff @(posedge CLK or posedge RST)
			begin
				if (RST)
				begin
					chan_q[gi] <= CHAN_RST;
					ind_q[gi] <= BYTE_RST;
					reth_q[gi] <= BYTE_RST;
					retl_q[gi] <= BYTE_RST;
					rsav_q[gi] <= BYTE_RST;
				end
				else
				begin
					if (FUNC_ACCEPT[gi])
						chan_q[gi] <= FUNC_CHAN_ADDR;
					if (IND_WR[gi])
					begin
						ind_q[gi][BIT_LAST_BLK] <= IND_IN[0];
						ind_q[gi][BIT_LAST_CHR] <= IND_IN[1];
						ind_q[gi][BIT_EQUAL] <= IND_IN[2];
					end
					if (SUB_BRANCH[gi])
					begin
						reth_q[gi] <= {RET_ADDR_IN[11:8], 4'h0};
						retl_q[gi] <= RET_ADDR_IN[7:0];
					end
					if (R_SAVE[gi])
						rsav_q[gi] <= R_IN;
				end
			end

			assign BLK_STATUS[gi] = blk_q[gi];
			assign BLK_STATUS_MEANINGFUL[gi] = meaningful_q[gi];
			assign CHAN_ACTIVE[gi] = active;
			assign INDICATORS[gi] = {ind_q[gi][BIT_EQUAL], ind_q[gi][BIT_LAST_CHR],
				ind_q[gi][BIT_LAST_BLK]};
			assign RET_ADDR[gi] = {reth_q[gi][7:4], retl_q[gi]};
		end
	endgenerate

	// ------------------------------------------------------------------
	// Table byte lookup shared by program and host reads
	// ------------------------------------------------------------------
	function automatic logic [7:0] tbl_byte(input logic [5:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			OFS_ST1_RX: v = st1_q[0];
			OFS_ST2_RX: v = st2_q[0];
			OFS_ST1_TX: v = st1_q[1];
			OFS_ST2_TX: v = st2_q[1];
			OFS_CHAN_RX: v = chan_q[0][9:2];
			OFS_CHAN_TX: v = chan_q[1][9:2];
			OFS_IND_RX: v = ind_q[0];
			OFS_IND_TX: v = ind_q[1];
			OFS_RETH_RX: v = reth_q[0];
			OFS_RETH_TX: v = reth_q[1];
			OFS_RETL_RX: v = retl_q[0];
			OFS_RETL_TX: v = retl_q[1];
			OFS_RSAV_RX: v = rsav_q[0];
			OFS_RSAV_TX: v = rsav_q[1];
			OFS_TPTR: v = {2'b00, tptr_q};
			default: v = 8'h00;
		endcase
		return v;
	endfunction : tbl_byte

	// ------------------------------------------------------------------
	// Table pointer and host / program read ports
	// ------------------------------------------------------------------
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			tptr_q <= 6'h00;
		else if (TPTR_WR)
			tptr_q <= TPTR_IN;
	end

	// Registered read data for both readers
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			PROG_RD_DATA <= BYTE_RST;
			HOST_TBL_DATA <= BYTE_RST;
			HOST_TBL_VALID <= 1'b0;
			HOST_STAT_DATA <= '0;
			HOST_STAT_VALID <= 1'b0;
			R_OUT <= BYTE_RST;
			R_OUT_VALID <= 1'b0;
		end
		else
		begin
			PROG_RD_DATA <= tbl_byte(PROG_RD_ADDR);
			HOST_TBL_VALID <= HOST_TBL_RD;
			if (HOST_TBL_RD)
				HOST_TBL_DATA <= tbl_byte(tptr_q);
			HOST_STAT_VALID <= |HOST_STAT_RD;
			if (HOST_STAT_RD[1])
				HOST_STAT_DATA <= blk_q[1];
			else if (HOST_STAT_RD[0])
				HOST_STAT_DATA <= blk_q[0];
			R_OUT_VALID <= |R_RESTORE;
			if (R_RESTORE[1])
				R_OUT <= rsav_q[1];
			else if (R_RESTORE[0])
				R_OUT <= rsav_q[0];
		end
	end

	// ------------------------------------------------------------------
	// Block mode read walker over the receive channel
	// ------------------------------------------------------------------
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			bmr_addr_q <= RAM_ADDR_RST;
			bmr_left_q <= RAM_ADDR_RST;
			BMR_REJECT <= 1'b0;
		end
		else
		begin
			BMR_REJECT <= BMR_START && (BMR_TX_CHAN || state_q[0] != CSA_IDLE);
			if (BMR_START && !BMR_TX_CHAN && state_q[0] == CSA_IDLE)
			begin
				bmr_addr_q <= BMR_ADDR;
				bmr_left_q <= BMR_RANGE;
			end
			else if (state_q[0] == CSA_BMR && bmr_left_q != 16'h0000)
			begin
				bmr_addr_q <= bmr_addr_q + 16'h0001;
				bmr_left_q <= bmr_left_q - 16'h0001;
			end
		end
	end

	assign BMR_BUSY = (state_q[0] == CSA_BMR);
	assign BMR_RAM_ADDR = bmr_addr_q;

endmodule : csa_channel_status

// File: rtl/csa_pkg.sv
// Package of constants and carrier types for the channel status accumulator
package csa_pkg;

	// ------------------------------------------------------------------
	// Line control table byte offsets (receive / transmit)
	// ------------------------------------------------------------------
	localparam logic [5:0] OFS_ST1_RX = 6'h10; // Status byte 1, receive (16)
	localparam logic [5:0] OFS_ST2_RX = 6'h11; // Status byte 2, receive (17)
	localparam logic [5:0] OFS_ST1_TX = 6'h30; // Status byte 1, transmit (48)
	localparam logic [5:0] OFS_ST2_TX = 6'h31; // Status byte 2, transmit (49)
	localparam logic [5:0] OFS_CHAN_RX = 6'h00; // Channel address byte (0)
	localparam logic [5:0] OFS_CHAN_TX = 6'h20; // Channel address byte (32)
	localparam logic [5:0] OFS_IND_RX = 6'h05; // Indicator byte (5)
	localparam logic [5:0] OFS_IND_TX = 6'h25; // Indicator byte (37)
	localparam logic [5:0] OFS_RETH_RX = 6'h12; // Return address high (18)
	localparam logic [5:0] OFS_RETH_TX = 6'h32; // Return address high (50)
	localparam logic [5:0] OFS_RETL_RX = 6'h13; // Return address low (19)
	localparam logic [5:0] OFS_RETL_TX = 6'h33; // Return address low (51)
	localparam logic [5:0] OFS_RSAV_RX = 6'h15; // Saved R-register (21)
	localparam logic [5:0] OFS_RSAV_TX = 6'h35; // Saved R-register (53)
	localparam logic [5:0] OFS_TPTR = 6'h37; // Table byte pointer (55)

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int BIT_APP_LO = 5; // Program-owned bit in status byte 1
	localparam int BIT_APP_HI = 6; // Program-owned bit in status byte 1
	localparam int BIT_INTERRUPT_REQUEST_INSTR = 0; // Interrupt-request bit
	localparam int BIT_DSET = 1; // Data set change bit
	localparam int BIT_VALID = 3; // Status meaningful bit in block byte
	localparam int BIT_LAST_BLK = 2;
	localparam int BIT_LAST_CHR = 5;
	localparam int BIT_EQUAL = 6;

	// ------------------------------------------------------------------
	// Reset values and fixed figures
	// ------------------------------------------------------------------
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [9:0] CHAN_RST = 10'h000;
	localparam logic [11:0] RET_RST = 12'h000;
	localparam logic [15:0] RAM_ADDR_RST = 16'h0000;
	localparam int NUM_CHAN = 2; // 0 = receive, 1 = transmit

	// ------------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------------
	typedef enum logic [1:0]
	{
		CSA_IDLE = 2'b00,
		CSA_ACTIVE = 2'b01,
		CSA_BMR = 2'b10
	} csa_state_type;

	typedef struct packed
	{
		logic [7:0] byte6;
		logic [7:0] byte7;
	} csa_blk_status_type;

	typedef struct packed
	{
		logic set_valid; // Set a detected status condition
		logic [7:0] set_mask; // Which status byte 1 bits to set
		logic [7:0] set_mask2; // Which status byte 2 bits to set
	} csa_status_event_type;

endpackage : csa_pkg

// File: tb/csa_channel_status_sva.sv
// Checker for the channel status accumulator ports
module csa_channel_status_sva
	import csa_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic [NUM_CHAN-1:0] BLK_START,
	input wire logic [NUM_CHAN-1:0] BLK_END,
	input wire logic VARIANT_SPLIT,
	input wire logic [NUM_CHAN-1:0] INTERRUPT_REQUEST_INSTR_INSTR,
	input wire logic [NUM_CHAN-1:0] HOST_STAT_RD,
	input wire logic HOST_STAT_VALID,
	input wire csa_blk_status_type [NUM_CHAN-1:0] BLK_STATUS,
	input wire logic [NUM_CHAN-1:0] BLK_STATUS_MEANINGFUL,
	input wire logic [NUM_CHAN-1:0] CHAN_ACTIVE,
	input wire logic BMR_START,
	input wire logic BMR_TX_CHAN,
	input wire logic [15:0] BMR_ADDR,
	input wire logic [15:0] BMR_RANGE,
	input wire logic BMR_BUSY,
	input wire logic [15:0] BMR_RAM_ADDR,
	input wire logic BMR_REJECT,
	input wire logic [NUM_CHAN-1:0] SUB_BRANCH,
	input wire logic [11:0] RET_ADDR_IN,
	input wire logic [NUM_CHAN-1:0] [11:0] RET_ADDR
);
	timeunit 1ns;
	timeprecision 1ns;
	// -----------------------------------------------------------
	// Block lifecycle
	// -----------------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	property p_go;
		BLK_START[0] && !CHAN_ACTIVE[0] && !BLK_END[0] && !BMR_BUSY && !BMR_START |=> CHAN_ACTIVE[0];
	endproperty
	a_go: assert property (p_go) else $error("block not activated");
	property p_end;
		CHAN_ACTIVE[1] && BLK_END[1] && !BLK_START[1] |=> !CHAN_ACTIVE[1] && BLK_STATUS_MEANINGFUL[1];
	endproperty
	a_end: assert property (p_end) else $error("block end not taken");
	property p_valid;
		CHAN_ACTIVE[0] && BLK_END[0] |=>
			($past(VARIANT_SPLIT) ? BLK_STATUS[0].byte6[3] : BLK_STATUS[0].byte7[3]);
	endproperty
	a_valid: assert property (p_valid) else $error("meaningful bit missing");
	property p_interrupt_request_instr;
		CHAN_ACTIVE[0] && BLK_END[0] && INTERRUPT_REQUEST_INSTR_INSTR[0] && !VARIANT_SPLIT |=> BLK_STATUS[0].byte7[0];
	endproperty
	a_interrupt_request_instr: assert property (p_interrupt_request_instr) else $error("interrupt bit missing");
	property p_stat;
		|HOST_STAT_RD |=> HOST_STAT_VALID;
	endproperty
	a_stat: assert property (p_stat) else $error("status read unanswered");
	// -----------------------------------------------------------
	// Block mode read and working bytes
	// -----------------------------------------------------------
	property p_rej;
		BMR_START && BMR_TX_CHAN |=> BMR_REJECT;
	endproperty
	a_rej: assert property (p_rej) else $error("transmit block read accepted");
	property p_bgo;
		BMR_START && !BMR_TX_CHAN && !BMR_BUSY && !CHAN_ACTIVE[0] && BMR_RANGE != 16'h0000 |=>
			BMR_BUSY && BMR_RAM_ADDR == $past(BMR_ADDR);
	endproperty
	a_bgo: assert property (p_bgo) else $error("block read start address wrong");
	property p_step;
		BMR_BUSY && $past(BMR_BUSY) |-> BMR_RAM_ADDR == 16'($past(BMR_RAM_ADDR) + 16'h0001);
	endproperty
	a_step: assert property (p_step) else $error("block read address not stepping");
	property p_bdone;
		$fell(BMR_BUSY) |-> ##[0:1] !BLK_STATUS_MEANINGFUL[0];
	endproperty
	a_bdone: assert property (p_bdone) else $error("block read status marked valid");
	property p_ret;
		SUB_BRANCH[1] |=> RET_ADDR[1] == $past(RET_ADDR_IN);
	endproperty
	a_ret: assert property (p_ret) else $error("return address not saved");
	c_blk: cover property (CHAN_ACTIVE[0] && BLK_END[0]);
	c_bmr: cover property ($fell(BMR_BUSY));
	c_rej: cover property (BMR_REJECT);
endmodule : csa_channel_status_sva

bind csa_channel_status csa_channel_status_sva i_sva (.CLK, .RST, .BLK_START, .BLK_END,
	.VARIANT_SPLIT, .INTERRUPT_REQUEST_INSTR_INSTR, .HOST_STAT_RD, .HOST_STAT_VALID, .BLK_STATUS,
	.BLK_STATUS_MEANINGFUL, .CHAN_ACTIVE, .BMR_START, .BMR_TX_CHAN, .BMR_ADDR, .BMR_RANGE,
	.BMR_BUSY, .BMR_RAM_ADDR, .BMR_REJECT, .SUB_BRANCH, .RET_ADDR_IN, .RET_ADDR);

// File: tb/csa_host_model.sv
// Host program model issuing status and table byte reads
module csa_host_model
	import csa_pkg::*;
(
	input wire logic CLK,
	output logic [1:0] HOST_STAT_RD,
	output logic HOST_TBL_RD,
	output logic TPTR_WR,
	output logic [5:0] TPTR_IN
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle levels
	initial
	begin
		{HOST_STAT_RD, HOST_TBL_RD, TPTR_WR, TPTR_IN} = '0;
	end
	// Block status read, one cycle wide
	task automatic stat_rd(input int ch);
		@(negedge CLK);
		HOST_STAT_RD[ch] = 1'b1;
		@(negedge CLK);
		HOST_STAT_RD = 2'h0;
	endtask : stat_rd
	// Load the table pointer, then fetch the byte it names
	task automatic tbl_rd(input logic [5:0] ofs);
		@(negedge CLK);
		TPTR_WR = 1'b1;
		TPTR_IN = ofs;
		@(negedge CLK);
		TPTR_WR = 1'b0;
		TPTR_IN = ~ofs; // Pointer value no longer held
		HOST_TBL_RD = 1'b1;
		@(negedge CLK);
		HOST_TBL_RD = 1'b0;
	endtask : tbl_rd
endmodule : csa_host_model

// File: tb/channel_status_accumulator_bench.sv
// Self-checking bench for the channel status accumulator
module channel_status_accumulator_bench;
	import csa_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK, RST, VARIANT_SPLIT, BMR_START, BMR_TX_CHAN, HOST_TBL_RD, TPTR_WR;
	logic [1:0] BLK_START, BLK_END, INTERRUPT_REQUEST_INSTR_INSTR, DSET_INTERRUPT_REQUEST_INSTR, APP_WR, FUNC_ACCEPT, IND_WR;
	logic [1:0] SUB_BRANCH, R_SAVE, R_RESTORE, HOST_STAT_RD, BLK_STATUS_MEANINGFUL, CHAN_ACTIVE;
	csa_status_event_type [1:0] STATUS_EVT;
	csa_blk_status_type [1:0] BLK_STATUS;
	csa_blk_status_type HOST_STAT_DATA;
	logic [1:0][1:0] APP_BITS;
	logic [1:0][2:0] INDICATORS;
	logic [1:0][11:0] RET_ADDR;
	logic [15:0] BMR_ADDR, BMR_RANGE, BMR_RAM_ADDR, want_s, a, seen_v;
	logic [9:0] FUNC_CHAN_ADDR;
	logic [2:0] IND_IN;
	logic [11:0] RET_ADDR_IN;
	logic [7:0] R_IN, PROG_RD_DATA, HOST_TBL_DATA, R_OUT, m1, m2, b7;
	logic [5:0] TPTR_IN, PROG_RD_ADDR, st, k;
	logic HOST_TBL_VALID, HOST_STAT_VALID, R_OUT_VALID, BMR_BUSY, BMR_REJECT;
	logic [1:0] ab;
	logic [5:0] ofs [6];
	logic [7:0] want [6];
	logic [15:0] notes [$];
	int n_mismatch = 0;
	int n_checks = 0;
	int cycles = 0;
	csa_channel_status i_dut (.CLK, .RST, .BLK_START, .BLK_END, .VARIANT_SPLIT, .INTERRUPT_REQUEST_INSTR_INSTR,
		.DSET_INTERRUPT_REQUEST_INSTR, .STATUS_EVT, .APP_WR, .APP_BITS, .BMR_START, .BMR_TX_CHAN, .BMR_ADDR,
		.BMR_RANGE, .FUNC_ACCEPT, .FUNC_CHAN_ADDR, .IND_WR, .IND_IN, .SUB_BRANCH, .RET_ADDR_IN,
		.R_SAVE, .R_RESTORE, .R_IN, .TPTR_WR, .TPTR_IN, .PROG_RD_ADDR, .HOST_TBL_RD,
		.HOST_STAT_RD, .PROG_RD_DATA, .HOST_TBL_DATA, .HOST_TBL_VALID, .BLK_STATUS,
		.BLK_STATUS_MEANINGFUL, .HOST_STAT_DATA, .HOST_STAT_VALID, .CHAN_ACTIVE, .INDICATORS,
		.RET_ADDR, .R_OUT, .R_OUT_VALID, .BMR_BUSY, .BMR_RAM_ADDR, .BMR_REJECT);
	csa_host_model i_host (.CLK, .HOST_STAT_RD, .HOST_TBL_RD, .TPTR_WR, .TPTR_IN);
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp_v);
		n_checks++;
		if (seen !== exp_v)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp_v);
		end
	endtask : check
	task automatic test_done();
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	// Next falling edge, with all one-cycle requests dropped
	task automatic tick();
		@(negedge CLK);
		{BLK_START, BLK_END, INTERRUPT_REQUEST_INSTR_INSTR, DSET_INTERRUPT_REQUEST_INSTR, APP_WR, FUNC_ACCEPT, IND_WR, SUB_BRANCH,
			R_SAVE, R_RESTORE, BMR_START} = '0;
		STATUS_EVT = '0;
	endtask : tick
	// Clock and hang guard
	initial
	begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_mismatch++;
			test_done();
		end
	end
	// Host-visible answers against the oldest note
	always @(negedge CLK)
		if (!RST && (HOST_STAT_VALID || HOST_TBL_VALID || R_OUT_VALID))
		begin
			seen_v = HOST_STAT_VALID ? HOST_STAT_DATA : {8'h00, HOST_TBL_VALID ? HOST_TBL_DATA : R_OUT};
			check(seen_v, notes.size() > 0 ? notes.pop_front() : 16'hxxxx);
		end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		{BLK_START, BLK_END, INTERRUPT_REQUEST_INSTR_INSTR, DSET_INTERRUPT_REQUEST_INSTR, APP_WR, FUNC_ACCEPT, IND_WR, SUB_BRANCH,
			R_SAVE, R_RESTORE, BMR_START} = '0;
		{VARIANT_SPLIT, APP_BITS, BMR_TX_CHAN, BMR_ADDR, BMR_RANGE, FUNC_CHAN_ADDR, IND_IN,
			RET_ADDR_IN, R_IN, PROG_RD_ADDR, STATUS_EVT} = '0;
		RST = 1'b1;
		void'($urandom(4));
		repeat (8) @(negedge CLK);
		RST = 1'b0;
		check(CHAN_ACTIVE, 0);
		check(BLK_STATUS[0], 0);
		// Status blocks in both variants on both channels
		for (int v = 0; v < 2; v++)
			for (int c = 0; c < 2; c++)
			begin
				m1 = 8'($urandom) & 8'h96;
				m2 = 8'($urandom) & 8'hf4;
				ab = 2'($urandom);
				st = c ? OFS_ST1_TX : OFS_ST1_RX;
				tick();
				VARIANT_SPLIT = 1'(v);
				INTERRUPT_REQUEST_INSTR_INSTR[c] = 1'b1; // Ignored while idle
				tick();
				BLK_START[c] = 1'b1;
				tick();
				STATUS_EVT[c] = {1'b1, m1, m2};
				APP_WR[c] = 1'b1;
				APP_BITS[c] = ab;
				DSET_INTERRUPT_REQUEST_INSTR[c] = 1'b1;
				PROG_RD_ADDR = st;
				tick();
				tick();
				check(PROG_RD_DATA, m1 | {1'b0, ab, 5'h00});
				notes.push_back({8'h00, m1 | {1'b0, ab, 5'h00}});
				i_host.tbl_rd(st);
				PROG_RD_ADDR = st + 6'h01;
				BLK_END[c] = 1'b1;
				INTERRUPT_REQUEST_INSTR_INSTR[c] = (c == 0);
				tick();
				check(PROG_RD_DATA, m2 | 8'h02);
				b7 = m1 | {1'b0, ab, 5'h00} | {7'h00, c == 0};
				want_s = v ? {m2 | 8'h0a | {7'h00, c == 0}, b7} : {m2 | 8'h02, b7 | 8'h08};
				check(BLK_STATUS[c], want_s);
				check(BLK_STATUS_MEANINGFUL[c], 1);
				check(CHAN_ACTIVE[c], 0);
				tick();
				check(PROG_RD_DATA, 0);
				notes.push_back(want_s);
				i_host.stat_rd(c);
			end
		// Abnormal end: both channels of the pair reset in mid-block
		tick();
		BLK_START = 2'h3;
		tick();
		STATUS_EVT = {2{1'b1, 8'h80, 8'h80}};
		tick();
		RST = 1'b1;
		repeat (2) @(negedge CLK);
		RST = 1'b0;
		PROG_RD_ADDR = OFS_ST1_TX;
		tick();
		check(CHAN_ACTIVE, 0);
		check(PROG_RD_DATA, 0);
		check(BLK_STATUS_MEANINGFUL, 0);
		// Working bytes on both channels
		ofs = '{OFS_CHAN_RX, OFS_IND_RX, OFS_RETH_RX, OFS_RETL_RX, OFS_RSAV_RX, 6'h01};
		for (int c = 0; c < 2; c++)
		begin
			k = c ? 6'h20 : 6'h00;
			{FUNC_CHAN_ADDR, IND_IN, RET_ADDR_IN, R_IN} = 33'({$urandom, $urandom});
			{FUNC_ACCEPT[c], IND_WR[c], SUB_BRANCH[c], R_SAVE[c]} = 4'hf;
			tick();
			check(INDICATORS[c], IND_IN);
			check(RET_ADDR[c], RET_ADDR_IN);
			want = '{FUNC_CHAN_ADDR[9:2], {1'b0, IND_IN[2:1], 2'h0, IND_IN[0], 2'h0},
				{RET_ADDR_IN[11:8], 4'h0}, RET_ADDR_IN[7:0], R_IN, 8'h00};
			for (int i = 0; i < 6; i++)
			begin
				PROG_RD_ADDR = ofs[i] | k;
				tick();
				check(PROG_RD_DATA, want[i]);
			end
			notes.push_back({8'h00, R_IN});
			R_RESTORE[c] = 1'b1;
			tick();
			notes.push_back({8'h00, R_IN});
			i_host.tbl_rd(OFS_RSAV_RX | k);
		end
		// Block mode read, refusal while busy and on transmit
		a = 16'($urandom);
		BMR_ADDR = a;
		BMR_RANGE = 16'h0004;
		BMR_START = 1'b1;
		@(negedge CLK);
		check(BMR_BUSY, 1);
		check(BMR_RAM_ADDR, a);
		tick();
		check(BMR_REJECT, 1);
		for (int i = 0; i < 20 && BMR_BUSY; i++)
			tick();
		check(BMR_BUSY, 0);
		check(BLK_STATUS_MEANINGFUL[0], 0);
		check(BLK_STATUS[0], 16'(a + 16'h0004));
		BMR_TX_CHAN = 1'b1;
		BMR_START = 1'b1;
		tick();
		check(BMR_REJECT, 1);
		check(BMR_BUSY, 0);
		tick();
		check(notes.size(), 0);
		test_done();
	end
endmodule : channel_status_accumulator_bench
